// ### rtl/gcce_top.sv
/*
 Controller-side command encoder: builds command, address, secondary and
 data bytes for the instrument bus, tracks active and system controller
 status and the primary address, and runs the pass-control sequence.
 Assumes a byte handshake engine on clk that takes gpib_byte/atn/eoi when
 gpib_valid and gpib_ready are both high, and a bus decoder that pulses
 take_ctrl_rx when control is passed to this interface.
*/
// Design decision made here: the AHB-Lite register port.
`include "gcce_params.svh"

// What this block does
// - Listen address byte is 32 plus primary address, MSB clear or set.
// - Talk address byte is 64 plus primary address, MSB clear or set.
// - Parallel poll enable carries a 4-bit mask, codes 96 to 111.
// - Parallel poll disable is byte 112, or 240 with MSB set.
// - Poll enable or disable only right after configure to a listener.
// - Fixed single-byte command codes; all but lockout may add 128.
// - Status bit 7 shows system controller configuration.
// - Status bit 6 shows this interface is active controller.
// - Status bits 4 to 0 hold the primary address, 0 to 30.
// - Power-on address is 21 as system controller, else 20.
// - A written address above 30 is stored modulo 32, unless that gives 31, which is ignored.
// - Address 31 is never used as a device address.
// - Pass control sends the new controller's talk address, then take control.
// - After the take control byte of a pass control is accepted, the old controller drops active status.
// - Commands go out with attention asserted, data with it deasserted.
// - A requested end marker goes out with the final data byte.
// - Standard commands clear the MSB; the raw path may set it.
// - Command requests while not active controller are refused with an error.
module gcce_top
   import gcce_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Outgoing byte to the handshake engine
   output logic [7:0] gpib_byte,
   output logic gpib_atn,
   output logic gpib_eoi,
   output logic gpib_valid,
   input wire logic gpib_ready,
   // Controller role
   input wire logic sys_ctrl_pin,
   input wire logic take_ctrl_rx,
   output logic ctrl_active
);

   // ********
   // Declarations
   // ********
   logic [1:0] rd_idx;
   logic [31:0] rd_word;
   logic wr_stb;
   logic [1:0] wr_idx;
   logic [31:0] wr_data;
   logic sys_ctrl_lvl;

   gcce_state_t state_ff;
   logic [1:0] init_cnt_ff;
   logic sys_ctrl_ff;
   logic active_ff;
   logic [`GCCE_ADDR_W-1:0] addr_ff;
   logic listener_ff;
   logic ppc_armed_ff;
   logic [16:0] cmd_last_ff;
   logic [7:0] byte_ff;
   logic atn_ff;
   logic eoi_ff;
   logic err_busy_ff;
   logic err_notac_ff;
   logic err_seq_ff;

   logic cmd_wr;
   gcce_op_t req_op;
   logic [7:0] req_arg;
   logic req_end;
   logic req_is_cmd;
   logic req_is_sec;
   logic req_accept;
   logic rej_busy;
   logic rej_notac;
   logic rej_seq;
   logic [7:0] req_byte;
   logic byte_done;
   logic err_clr_wr;
   logic addr_wr;
   logic [`GCCE_ADDR_W-1:0] wr_addr;

   // ********
   // Bus slave and strap synchroniser
   // ********
   gcce_ahb_slave u_slave (
      .clk(clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .hwdata(hwdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .rd_idx(rd_idx),
      .rd_word(rd_word),
      .wr_stb(wr_stb),
      .wr_idx(wr_idx),
      .wr_data(wr_data)
   );

   gcce_sync u_sys_sync (
      .clk(clk),
      .rst(rst),
      .pin_in(sys_ctrl_pin),
      .level_out(sys_ctrl_lvl)
   );

   // ********
   // Request decode
   // ********
   // Command register write fields
   assign cmd_wr = wr_stb & (wr_idx == `GCCE_IDX_CMD);
   assign req_op = gcce_op_t'(wr_data[`GCCE_CMD_OP_MSB:`GCCE_CMD_OP_LSB]);
   assign req_arg = wr_data[`GCCE_CMD_ARG_MSB:`GCCE_CMD_ARG_LSB];
   assign req_end = wr_data[`GCCE_CMD_END_BIT];
   assign req_is_sec = (req_op == GCCE_OP_PPE) | (req_op == GCCE_OP_PPD);
   // Everything but a data byte needs the controller role
   assign req_is_cmd = (req_op != GCCE_OP_DATA);

   // Refusals: busy first, then role, then secondary ordering
   assign rej_busy = cmd_wr & (state_ff != GCCE_ST_IDLE);
   assign rej_notac = cmd_wr & ~rej_busy & req_is_cmd & ~active_ff;
   assign rej_seq = cmd_wr & ~rej_busy & ~rej_notac & req_is_sec & ~ppc_armed_ff;
   assign req_accept = cmd_wr & ~rej_busy & ~rej_notac & ~rej_seq;

   // Byte encoding per opcode; MSB cleared except on the raw and data paths
   always_comb begin
      req_byte = 8'h00;
      case (req_op)
         GCCE_OP_GTL: req_byte = `GCCE_CODE_GTL;
         GCCE_OP_SDC: req_byte = `GCCE_CODE_SDC;
         GCCE_OP_PPC: req_byte = `GCCE_CODE_PPC;
         GCCE_OP_GET: req_byte = `GCCE_CODE_GET;
         GCCE_OP_TCT: req_byte = `GCCE_CODE_TCT;
         GCCE_OP_LLO: req_byte = `GCCE_CODE_LLO;
         GCCE_OP_DCL: req_byte = `GCCE_CODE_DCL;
         GCCE_OP_PPU: req_byte = `GCCE_CODE_PPU;
         GCCE_OP_SPE: req_byte = `GCCE_CODE_SPE;
         GCCE_OP_SPD: req_byte = `GCCE_CODE_SPD;
         GCCE_OP_UNL: req_byte = `GCCE_CODE_UNL;
         GCCE_OP_UNT: req_byte = `GCCE_CODE_UNT;
         GCCE_OP_LISTEN: req_byte = {`GCCE_PFX_LISTEN, req_arg[4:0]};
         GCCE_OP_TALK: req_byte = {`GCCE_PFX_TALK, req_arg[4:0]};
         GCCE_OP_MLA: req_byte = {`GCCE_PFX_LISTEN, addr_ff};
         GCCE_OP_MTA: req_byte = {`GCCE_PFX_TALK, addr_ff};
         GCCE_OP_PPE: req_byte = {`GCCE_PFX_PPE, req_arg[3:0]};
         GCCE_OP_PPD: req_byte = `GCCE_CODE_PPD;
         GCCE_OP_RAW: req_byte = req_arg;
         GCCE_OP_DATA: req_byte = req_arg;
         GCCE_OP_PASS: req_byte = {`GCCE_PFX_TALK, req_arg[4:0]};
         default: req_byte = 8'h00;
      endcase
   end

   // Handshake completes on the edge where both sides agree
   assign byte_done = gpib_valid & gpib_ready;

   // ********
   // Sequencer
   // ********
   // Init waits for the strap synchroniser before taking the role
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= GCCE_ST_INIT;
         init_cnt_ff <= 2'h0;
      end else begin
         case (state_ff)
            GCCE_ST_INIT: begin
               init_cnt_ff <= init_cnt_ff + 2'h1;
               if (init_cnt_ff == `GCCE_INIT_CYCLES) begin
                  state_ff <= GCCE_ST_IDLE;
               end
            end
            GCCE_ST_IDLE: begin
               if (req_accept) begin
                  state_ff <= (req_op == GCCE_OP_PASS) ? GCCE_ST_PASS_TALK : GCCE_ST_SEND;
               end
            end
            GCCE_ST_SEND: begin
               if (byte_done) begin
                  state_ff <= GCCE_ST_IDLE;
               end
            end
            GCCE_ST_PASS_TALK: begin
               if (byte_done) begin
                  state_ff <= GCCE_ST_PASS_TCT;
               end
            end
            GCCE_ST_PASS_TCT: begin
               if (byte_done) begin
                  state_ff <= GCCE_ST_IDLE;
               end
            end
            default: state_ff <= GCCE_ST_IDLE;
         endcase
      end
   end

   // Outgoing byte, attention and end marker held until taken
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         byte_ff <= 8'h00;
         atn_ff <= 1'b0;
         eoi_ff <= 1'b0;
      end else if (state_ff == GCCE_ST_IDLE && req_accept) begin
         byte_ff <= req_byte;
         atn_ff <= req_is_cmd;
         eoi_ff <= ~req_is_cmd & req_end;
      end else if (state_ff == GCCE_ST_PASS_TALK && byte_done) begin
         byte_ff <= `GCCE_CODE_TCT;
         atn_ff <= 1'b1;
         eoi_ff <= 1'b0;
      end
   end

   // Last accepted request, read back from the command register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_last_ff <= 17'h00000;
      end else if (req_accept) begin
         cmd_last_ff <= wr_data[16:0];
      end
   end

   assign gpib_valid = (state_ff == GCCE_ST_SEND) | (state_ff == GCCE_ST_PASS_TALK) |
                       (state_ff == GCCE_ST_PASS_TCT);
   assign gpib_byte = byte_ff;
   assign gpib_atn = atn_ff;
   assign gpib_eoi = eoi_ff;

   // ********
   // Listener and poll-configure tracking
   // ********
   // A listener exists once a listen or MLA request (not a raw byte) went out; unlisten clears it.
   // Tracked at request time; configure arms it when a listener exists, poll enable and disable hold it, and any other request, data too, disarms it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         listener_ff <= 1'b0;
         ppc_armed_ff <= 1'b0;
      end else if (req_accept) begin
         case (req_op)
            GCCE_OP_LISTEN, GCCE_OP_MLA: begin
               listener_ff <= (req_arg[4:0] != `GCCE_ADDR_UNUSED) | (req_op == GCCE_OP_MLA);
               ppc_armed_ff <= 1'b0;
            end
            GCCE_OP_UNL: begin
               listener_ff <= 1'b0;
               ppc_armed_ff <= 1'b0;
            end
            GCCE_OP_PPC: ppc_armed_ff <= listener_ff;
            GCCE_OP_PPE, GCCE_OP_PPD: ppc_armed_ff <= ppc_armed_ff;
            default: ppc_armed_ff <= 1'b0;
         endcase
      end
   end

   // ********
   // Controller role and primary address
   // ********
   assign addr_wr = wr_stb & (wr_idx == `GCCE_IDX_CSA);
   assign wr_addr = wr_data[`GCCE_ADDR_W-1:0];

   // Strap caught after release; address default follows it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sys_ctrl_ff <= 1'b0;
         addr_ff <= `GCCE_ADDR_NONSYS;
      end else if (state_ff == GCCE_ST_INIT && init_cnt_ff == `GCCE_INIT_CYCLES) begin
         sys_ctrl_ff <= sys_ctrl_lvl;
         addr_ff <= sys_ctrl_lvl ? `GCCE_ADDR_SYS : `GCCE_ADDR_NONSYS;
      end else if (addr_wr && wr_addr != `GCCE_ADDR_UNUSED) begin
         addr_ff <= wr_addr;
      end
   end

   // System controller starts active; role moves only by take control
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         active_ff <= 1'b0;
      end else if (state_ff == GCCE_ST_INIT && init_cnt_ff == `GCCE_INIT_CYCLES) begin
         active_ff <= sys_ctrl_lvl;
      end else if (take_ctrl_rx) begin
         active_ff <= 1'b1;
      end else if (state_ff == GCCE_ST_PASS_TCT && byte_done) begin
         active_ff <= 1'b0;
      end
   end

   assign ctrl_active = active_ff;

   // ********
   // Error flags
   // ********
   // Write one to clear; a new refusal in the same cycle wins
   assign err_clr_wr = wr_stb & (wr_idx == `GCCE_IDX_ERR);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         err_busy_ff <= 1'b0;
         err_notac_ff <= 1'b0;
         err_seq_ff <= 1'b0;
      end else begin
         if (rej_busy) begin
            err_busy_ff <= 1'b1;
         end else if (err_clr_wr && wr_data[`GCCE_ERR_OVR_BIT]) begin
            err_busy_ff <= 1'b0;
         end
         if (rej_notac) begin
            err_notac_ff <= 1'b1;
         end else if (err_clr_wr && wr_data[`GCCE_ERR_NOTAC_BIT]) begin
            err_notac_ff <= 1'b0;
         end
         if (rej_seq) begin
            err_seq_ff <= 1'b1;
         end else if (err_clr_wr && wr_data[`GCCE_ERR_SEQ_BIT]) begin
            err_seq_ff <= 1'b0;
         end
      end
   end

   // ********
   // Register read mux
   // ********
   always_comb begin
      rd_word = 32'h00000000;
      case (rd_idx)
         `GCCE_IDX_CMD: rd_word = {15'h0000, cmd_last_ff};
         `GCCE_IDX_ERR: begin
            rd_word[`GCCE_ERR_BUSY_BIT] = (state_ff != GCCE_ST_IDLE);
            rd_word[`GCCE_ERR_NOTAC_BIT] = err_notac_ff;
            rd_word[`GCCE_ERR_SEQ_BIT] = err_seq_ff;
            rd_word[`GCCE_ERR_OVR_BIT] = err_busy_ff;
            rd_word[`GCCE_ERR_LSN_BIT] = listener_ff;
         end
         `GCCE_IDX_CSA: begin
            rd_word[`GCCE_CSA_SYS_BIT] = sys_ctrl_ff;
            rd_word[`GCCE_CSA_AC_BIT] = active_ff;
            rd_word[5] = 1'b0;
            rd_word[`GCCE_ADDR_W-1:0] = addr_ff;
         end
         default: rd_word = 32'h00000000;
      endcase
   end

endmodule

// ### rtl/gcce_params.svh
/*
 Constants of the bus command encoder: register indices, field positions,
 reset values, command byte codes and the strap settle count.
 Assumes it is included by its bare name from every file that needs it.
*/
`ifndef GCCE_PARAMS_SVH
`define GCCE_PARAMS_SVH

// ********
// Register indices (byte address is four times the index)
// ********
`define GCCE_IDX_CMD 2'h0
`define GCCE_IDX_ERR 2'h2
`define GCCE_IDX_CSA 2'h3

// ********
// Command register fields
// ********
`define GCCE_CMD_OP_LSB 0
`define GCCE_CMD_OP_MSB 4
`define GCCE_CMD_ARG_LSB 8
`define GCCE_CMD_ARG_MSB 15
`define GCCE_CMD_END_BIT 16

// ********
// Error/status register fields
// ********
`define GCCE_ERR_BUSY_BIT 0
`define GCCE_ERR_NOTAC_BIT 1
`define GCCE_ERR_SEQ_BIT 2
`define GCCE_ERR_OVR_BIT 3
`define GCCE_ERR_LSN_BIT 4

// ********
// Controller status and address fields
// ********
`define GCCE_CSA_SYS_BIT 7
`define GCCE_CSA_AC_BIT 6
`define GCCE_ADDR_W 5
`define GCCE_ADDR_SYS 5'h15
`define GCCE_ADDR_NONSYS 5'h14
`define GCCE_ADDR_UNUSED 5'h1F

// ********
// Command byte codes and prefixes
// ********
`define GCCE_CODE_GTL 8'h01
`define GCCE_CODE_SDC 8'h04
`define GCCE_CODE_PPC 8'h05
`define GCCE_CODE_GET 8'h08
`define GCCE_CODE_TCT 8'h09
`define GCCE_CODE_LLO 8'h11
`define GCCE_CODE_DCL 8'h14
`define GCCE_CODE_PPU 8'h15
`define GCCE_CODE_SPE 8'h18
`define GCCE_CODE_SPD 8'h19
`define GCCE_CODE_UNL 8'h3F
`define GCCE_CODE_UNT 8'h5F
`define GCCE_CODE_PPD 8'h70
`define GCCE_PFX_LISTEN 3'h1
`define GCCE_PFX_TALK 3'h2
`define GCCE_PFX_PPE 4'h6

// ********
// Strap settle count after reset release
// ********
`define GCCE_INIT_CYCLES 2'h3

`endif

// ### rtl/gcce_pkg.sv
/*
 Types of the bus command encoder: command opcodes and sequencer states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package gcce_pkg;

   // ****************************************************************
   // Opcodes written to the command register
   // ****************************************************************
   typedef enum logic [4:0] {
      GCCE_OP_GTL    = 5'h00,
      GCCE_OP_SDC    = 5'h01,
      GCCE_OP_PPC    = 5'h02,
      GCCE_OP_GET    = 5'h03,
      GCCE_OP_TCT    = 5'h04,
      GCCE_OP_LLO    = 5'h05,
      GCCE_OP_DCL    = 5'h06,
      GCCE_OP_PPU    = 5'h07,
      GCCE_OP_SPE    = 5'h08,
      GCCE_OP_SPD    = 5'h09,
      GCCE_OP_UNL    = 5'h0A,
      GCCE_OP_UNT    = 5'h0B,
      GCCE_OP_LISTEN = 5'h0C,
      GCCE_OP_TALK   = 5'h0D,
      GCCE_OP_MLA    = 5'h0E,
      GCCE_OP_MTA    = 5'h0F,
      GCCE_OP_PPE    = 5'h10,
      GCCE_OP_PPD    = 5'h11,
      GCCE_OP_RAW    = 5'h12,
      GCCE_OP_DATA   = 5'h13,
      GCCE_OP_PASS   = 5'h14
   } gcce_op_t;

   // ****************************************************************
   // Sequencer states
   // ****************************************************************
   typedef enum logic [2:0] {
      GCCE_ST_INIT,
      GCCE_ST_IDLE,
      GCCE_ST_SEND,
      GCCE_ST_PASS_TALK,
      GCCE_ST_PASS_TCT
   } gcce_state_t;

endpackage

// ### rtl/gcce_sync.sv
/*
 Two flip-flop level synchroniser for one pin.
 Assumes the pin changes slowly compared with clk.
*/
module gcce_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pin and synchronised level
   input wire logic pin_in,
   output logic level_out
);

   logic meta_ff;
   logic level_ff;

   // First stage feeds only the second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= 1'b0;
         level_ff <= 1'b0;
      end else begin
         meta_ff <= pin_in;
         level_ff <= meta_ff;
      end
   end

   assign level_out = level_ff;

endmodule

// ### rtl/gcce_ahb_slave.sv
/*
 AHB-Lite slave front end: decodes word accesses to a 16-byte window,
 hands writes to the register file in the data phase, and registers read
 data at the end of the address phase.
 Assumes single transfers with an idle cycle or more between them.
*/
module gcce_ahb_slave (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AHB-Lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Register file side
   output logic [1:0] rd_idx,
   input wire logic [31:0] rd_word,
   output logic wr_stb,
   output logic [1:0] wr_idx,
   output logic [31:0] wr_data
);

   logic addr_ok;
   logic mapped;
   logic wr_pend_ff;
   logic [1:0] wr_idx_ff;
   logic [31:0] hrdata_ff;

   // Address phase decode: word size, aligned, inside the window
   assign addr_ok = hsel & htrans[1] & hready;
   assign mapped = (haddr[31:4] == 28'h0000000) & (haddr[1:0] == 2'h0) & (hsize == 3'h2);
   assign rd_idx = haddr[3:2];

   // Write intent is carried into the data phase, where hwdata stands
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_pend_ff <= 1'b0;
         wr_idx_ff <= 2'h0;
      end else begin
         wr_pend_ff <= addr_ok & hwrite & mapped;
         if (addr_ok) begin
            wr_idx_ff <= haddr[3:2];
         end
      end
   end

   // Read data captured early so the data phase needs no wait state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata_ff <= 32'h00000000;
      end else if (addr_ok & ~hwrite) begin
         hrdata_ff <= mapped ? rd_word : 32'h00000000;
      end
   end

   assign wr_stb = wr_pend_ff;
   assign wr_idx = wr_idx_ff;
   assign wr_data = hwdata;
   assign hrdata = hrdata_ff;
   assign hreadyout = 1'b1; // Never inserts wait states
   assign hresp = 1'b0;     // Always OKAY

endmodule

// ### verif/gcce_asserts.sv
/*
 Port checker of the command encoder, bound onto gcce_top.
 Assumes one clock domain and the asynchronous high reset.
*/
module gcce_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Byte link and role
   input wire logic [7:0] gpib_byte,
   input wire logic gpib_atn,
   input wire logic gpib_eoi,
   input wire logic gpib_valid,
   input wire logic gpib_ready,
   input wire logic sys_ctrl_pin,
   input wire logic ctrl_active
);
   // ******************************************************
   // Helper state
   // ******************************************************
   logic [7:0] last_cmd_ff;
   logic tct_ff;
   logic rd_csa_ff;
   wire take = gpib_valid && gpib_ready;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Remembers the last command byte, since poll secondaries depend on it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_cmd_ff <= 8'h00;
         tct_ff <= 1'h0;
         rd_csa_ff <= 1'h0;
      end else begin
         if (take && gpib_atn) last_cmd_ff <= gpib_byte;
         tct_ff <= take && gpib_atn && gpib_byte == 8'h09;
         rd_csa_ff <= hsel && htrans[1] && hready && !hwrite && haddr == 32'hC && hsize == 3'h2;
      end
   end
   // ******************************************************
   // Properties
   // ******************************************************
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
   a_byte_holds: assert property (gpib_valid && !gpib_ready |=> gpib_valid &&
      $stable(gpib_byte) && $stable(gpib_atn) && $stable(gpib_eoi)) else $error("byte moved");
   a_eoi_data: assert property (gpib_valid && gpib_eoi |-> !gpib_atn)
      else $error("end marker on a command");
   a_cmd_active: assert property ($rose(gpib_valid) && gpib_atn |-> $past(ctrl_active))
      else $error("command while not active");
   a_seq_ppoll: assert property ($rose(gpib_valid) && gpib_atn && gpib_byte[7:5] == 3'h3
      |-> last_cmd_ff[7:4] == 4'h6 || last_cmd_ff inside {8'h05, 8'h70})
      else $error("poll secondary out of order");
   a_tct_last: assert property (take && gpib_atn && gpib_byte == 8'h09 |=> !gpib_valid)
      else $error("byte after take control");
   a_active_drop: assert property ($fell(ctrl_active) |-> tct_ff)
      else $error("active lost without take control");
   a_init_role: assert property ($fell(rst) |-> ##4 ctrl_active == sys_ctrl_pin)
      else $error("wrong role after reset");
   a_status_read: assert property (rd_csa_ff |-> hrdata[31:8] == 24'h0 && !hrdata[5]
      && hrdata[4:0] != 5'h1F) else $error("bad status word");
endmodule

bind gcce_top gcce_asserts gcce_asserts_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .gpib_byte(gpib_byte), .gpib_atn(gpib_atn),
   .gpib_eoi(gpib_eoi), .gpib_valid(gpib_valid), .gpib_ready(gpib_ready),
   .sys_ctrl_pin(sys_ctrl_pin), .ctrl_active(ctrl_active));

// ### verif/gcce_partner.sv
/*
 Far side of the byte link: takes offered bytes with random stalls.
 Assumes the bench empties rx_q after each request.
*/
module gcce_partner (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Byte link
   input wire logic [7:0] gpib_byte,
   input wire logic gpib_atn,
   input wire logic gpib_eoi,
   input wire logic gpib_valid,
   output logic gpib_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] rx_q[$];
   // Stalls one cycle in three so that held bytes get exercised
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         gpib_ready <= 1'h0;
      end else begin
         gpib_ready <= ($urandom % 3) != 0;
         if (gpib_valid && gpib_ready) rx_q.push_back({gpib_atn, gpib_eoi, gpib_byte});
      end
   end
endmodule

// ### verif/gcce_top_tb_top.sv
/*
 Bench of the command encoder: bus tasks, byte checks, role changes.
 Assumes the partner model and the bound checker.
*/
module gcce_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, hsel = 0, hwrite = 0, sys_ctrl_pin = 1, take_ctrl_rx = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 0;
   logic hready, hreadyout, hresp, gpib_atn, gpib_eoi, gpib_valid, gpib_ready, ctrl_active;
   logic [7:0] gpib_byte;
   logic [4:0] adr;
   int errors = 0;
   int n_compared = 0;
   assign hready = hreadyout;
   // Clock at 200 MHz
   always #2.5 clk = ~clk;
   gcce_top gcce_top_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .gpib_byte(gpib_byte), .gpib_atn(gpib_atn),
      .gpib_eoi(gpib_eoi), .gpib_valid(gpib_valid), .gpib_ready(gpib_ready),
      .sys_ctrl_pin(sys_ctrl_pin), .take_ctrl_rx(take_ctrl_rx), .ctrl_active(ctrl_active));
   gcce_partner gcce_partner_inst (.clk(clk), .rst(rst), .gpib_byte(gpib_byte),
      .gpib_atn(gpib_atn), .gpib_eoi(gpib_eoi), .gpib_valid(gpib_valid), .gpib_ready(gpib_ready));
   // ******************************************************
   // Tasks and expectations
   // ******************************************************
   task automatic report_and_stop();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (e !== g) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One word transfer; the idle edge before it keeps reads out of write data phases
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clk); while (hready !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'h1);
      rd = hrdata;
      hsel <= 1'h0;
   endtask
   task automatic idle();
      for (int i = 0; i < 40; i++) begin
         ahb(1'h0, 32'h8, 32'h0);
         if (rd[0] === 1'h0) break;
      end
      chk("busy", 32'h0, {31'h0, rd[0]});
   endtask
   function automatic logic [7:0] eb(input logic [4:0] op, input logic [7:0] a);
      logic [7:0] t [12] = '{8'h01, 8'h04, 8'h05, 8'h08, 8'h09, 8'h11, 8'h14, 8'h15, 8'h18,
         8'h19, 8'h3F, 8'h5F};
      if (op < 5'h0C) return t[op];
      case (op)
         5'h0C: return {3'h1, a[4:0]};
         5'h0D: return {3'h2, a[4:0]};
         5'h0E: return {3'h1, adr};
         5'h0F: return {3'h2, adr};
         5'h10: return {4'h6, a[3:0]};
         5'h11: return 8'h70;
         default: return a;
      endcase
   endfunction
   task automatic sc(input logic [4:0] op, input logic [7:0] a, input logic e);
      logic [9:0] x;
      logic [9:0] y;
      ahb(1'h1, 32'h0, {15'h0, e, a, 3'h0, op});
      idle();
      x = {op != 5'h13, op == 5'h13 && e, eb(op, a)};
      y = (gcce_partner_inst.rx_q.size() == 1) ? gcce_partner_inst.rx_q[0] : 10'h3FF;
      gcce_partner_inst.rx_q.delete();
      chk("byte", {22'h0, x}, {22'h0, y});
   endtask
   // A refused request sends nothing and leaves a sticky flag to clear
   task automatic refuse(input logic [4:0] op, input logic [31:0] e);
      ahb(1'h1, 32'h0, {27'h0, op});
      idle();
      chk("err", e, rd & 32'hE);
      chk("sent", 32'h0, gcce_partner_inst.rx_q.size());
      ahb(1'h1, 32'h8, 32'hE);
      ahb(1'h0, 32'h8, 32'h0);
      chk("clear", 32'h0, rd & 32'hE);
   endtask
   // ******************************************************
   // Main sequence and watchdog
   // ******************************************************
   initial begin
      void'($urandom(15));
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      repeat (6) @(posedge clk);
      ahb(1'h0, 32'hC, 32'h0);
      chk("csa", 32'hD5, rd);
      ahb(1'h0, 32'h4, 32'h0);
      chk("hole", 32'h0, rd);
      ahb(1'h1, 32'hC, 32'hFF);
      ahb(1'h0, 32'hC, 32'h0);
      chk("csa", 32'hD5, rd);
      ahb(1'h1, 32'hC, 32'h2A);
      ahb(1'h0, 32'hC, 32'h0);
      chk("csa", 32'hCA, rd);
      adr = 5'h0A;
      for (int op = 0; op < 20; op++) begin
         if (op == 16) begin
            sc(5'h0C, 8'h03, 1'h0);
            sc(5'h02, 8'h00, 1'h0);
         end
         if (op != 18) sc(op[4:0], 8'($urandom % 31), 1'($urandom));
         if (op == 4) begin
            take_ctrl_rx <= 1'h1;
            @(posedge clk);
            take_ctrl_rx <= 1'h0;
         end
      end
      refuse(5'h11, 32'h4);
      sc(5'h12, 8'hBF, 1'h0);
      ahb(1'h1, 32'h0, {16'h0, 8'h14, 3'h0, 5'h14});
      idle();
      rd = (gcce_partner_inst.rx_q.size() == 2) ?
         {12'h0, gcce_partner_inst.rx_q[0], gcce_partner_inst.rx_q[1]} : 32'h0;
      gcce_partner_inst.rx_q.delete();
      chk("pass", 32'h00095209, rd);
      chk("active", 32'h0, {31'h0, ctrl_active});
      ahb(1'h0, 32'hC, 32'h0);
      chk("csa", 32'h8A, rd);
      refuse(5'h00, 32'h2);
      take_ctrl_rx <= 1'h1;
      @(posedge clk);
      take_ctrl_rx <= 1'h0;
      @(posedge clk);
      chk("active", 32'h1, {31'h0, ctrl_active});
      rst <= 1'h1;
      sys_ctrl_pin <= 1'h0;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      repeat (6) @(posedge clk);
      ahb(1'h0, 32'hC, 32'h0);
      chk("csa", 32'h14, rd);
      report_and_stop();
   end
   // Cuts a hang short well beyond the expected run time
   initial begin
      #200000;
      errors++;
      report_and_stop();
   end
endmodule
